/* tcm_pkg.sv */
/*
  constants, field layout and state carrier of one 16-bit timer channel
  with capture and waveform modes, reached over an APB slave port.
  assumes a single 50 MHz master clock and an async active-high reset.
*/
package tcm_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CHANNEL_MODE = 8'h04;
  localparam logic [7:0] OFS_COUNTER_VALUE = 8'h10;
  localparam logic [7:0] OFS_CAPTURE_COMPARE_A = 8'h14;
  localparam logic [7:0] OFS_CAPTURE_COMPARE_B = 8'h18;
  localparam logic [7:0] OFS_PERIOD_COMPARE_C = 8'h1c;
  localparam logic [7:0] OFS_CHANNEL_STATUS = 8'h20;
  localparam logic [31:0] RST_CHANNEL_MODE = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // ==========================================================
  // channel_mode field positions for both modes; from bit 6 up some positions mean a different field in each mode
  localparam int F_CLOCK_SELECT = 0;
  localparam int F_CLOCK_EDGE_INVERT = 3;
  localparam int F_CLOCK_GATE_SELECT = 4;
  localparam int F_STOP_BIT = 6;      // b load stop / c match stop
  localparam int F_DISABLE_BIT = 7;   // b load disable / c match disable
  localparam int F_EDGE_SELECT = 8;   // trigger edge / event edge
  localparam int F_TRIGGER_LINE_SELECT = 10;
  localparam int F_EVENT_LINE_SELECT = 10;
  localparam int F_EVENT_TRIGGER_ENABLE = 12;
  localparam int F_COMPARE_C_TRIGGER_ENABLE = 14;
  localparam int F_CAPTURE_OR_PULSE_MODE = 15;
  localparam int F_A_LOAD_EDGE_SELECT = 16;
  localparam int F_B_LOAD_EDGE_SELECT = 18;
  localparam int F_OUT_A_ON_COMPARE_A = 16;
  localparam int F_OUT_A_ON_COMPARE_C = 18;
  localparam int F_OUT_A_ON_EVENT = 20;
  localparam int F_OUT_A_ON_SOFT_TRIGGER = 22;
  localparam int F_OUT_B_ON_COMPARE_B = 24;
  localparam int F_OUT_B_ON_COMPARE_C = 26;
  localparam int F_OUT_B_ON_EVENT = 28;
  localparam int F_OUT_B_ON_SOFT_TRIGGER = 30;
  // channel_control command bits
  localparam int C_CLOCK_ENABLE = 0;
  localparam int C_CLOCK_DISABLE = 1;
  localparam int C_SOFT_TRIGGER = 2;
  // channel_status bits
  localparam int S_OVERFLOW = 0;
  localparam int S_LOAD_OVERRUN = 1;
  localparam int S_COMPARE_A = 2;
  localparam int S_COMPARE_B = 3;
  localparam int S_COMPARE_C = 4;
  localparam int S_LOAD_A = 5;
  localparam int S_LOAD_B = 6;
  localparam int S_EXT_TRIGGER = 7;
  localparam int S_CLOCK_ENABLED = 16;
  localparam int S_MIRROR_A = 17;
  localparam int S_MIRROR_B = 18;
  localparam int STICKY_W = 8;
  // ==========================================================
  // clock sources: prescaler bit per divided rate
  localparam int DIV2_BIT = 0;
  localparam int DIV8_BIT = 2;
  localparam int DIV32_BIT = 4;
  localparam int DIV128_BIT = 6;
  localparam int DIV1024_BIT = 9;
  localparam int PRESCALE_W = 10;
  localparam logic [2:0] SEL_DIV2 = 3'h0;
  localparam logic [2:0] SEL_DIV8 = 3'h1;
  localparam logic [2:0] SEL_DIV32 = 3'h2;
  localparam logic [2:0] SEL_DIV128 = 3'h3;
  localparam logic [2:0] SEL_DIV1024 = 3'h4;
  localparam logic [2:0] SEL_EXT0 = 3'h5;
  localparam logic [2:0] SEL_EXT1 = 3'h6;
  // edge and output action encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  // synchroniser slots: three ext clock lines then the two io lines
  localparam int SY_IO_A = 3;
  localparam int SY_IO_B = 4;
  localparam int SY_W = 5;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic [SY_W-1:0] prev;
    logic [PRESCALE_W-1:0] presc;
    logic clk_lvl_prev;
    logic [31:0] channel_mode;
    logic [15:0] count;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic [15:0] pc_c;
    logic clk_en;
    logic clk_run;
    logic [STICKY_W-1:0] sticky;
    logic a_unread;
    logic b_unread;
    logic io_a;
    logic io_b;
    logic io_a_oe;
    logic io_b_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcm_state_t;
endpackage

/* tcm_channel.sv */
/*
  one 16-bit timer/counter channel: clock select and gating, capture of
  the counter on io line a edges, waveform generation on io lines a/b,
  and an APB register slave.
  assumes APB on the same clock; io and ext clock pins are asynchronous.
*/
// Implementation choice: the APB slave port.
// Operation
// - clock from master/2,/8,/32,/128,/1024 or ext lines; optional AND gating.
// - edge invert chooses rising or falling edge of selected clock.
// - capture mode, b load stops the counter clock when enabled.
// - capture mode, b load disables the counter clock when enabled.
// - capture trigger edge: none, rising, falling or each.
// - capture trigger line is io b when 0, io a when 1.
// - compare c match resets counter and starts clock when enabled.
// - mode bit selects capture (0) or waveform (1) operation.
// - register a loads counter on selected edge of io a.
// - register b loads counter on selected edge of io a.
// - waveform mode, compare c match stops the clock when enabled.
// - waveform mode, compare c match disables the clock when enabled.
// - waveform event edge: none, rising, falling or each.
// - event line is io b or ext lines; io b then becomes input.
// - enabled event resets counter and starts clock; else only outputs.
// - four events set, clear or toggle io a.
// - four events set, clear or toggle io b.
// - counter value reads live 16-bit count, read-only, resets zero.
// - register a writable only in waveform mode.
// - same-cycle output events: software, event, compare c, compare a/b.
// - software trigger resets counter and starts clock.
// - overflow flag sticky until status read.
module tcm_channel
  import tcm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_CLOCK_LINE_0,
  input wire logic EXT_CLOCK_LINE_1,
  input wire logic EXT_CLOCK_LINE_2,
  input wire logic CHAN_IO_A_IN,
  output logic CHAN_IO_A_OUT,
  output logic CHAN_IO_A_OE,
  input wire logic CHAN_IO_B_IN,
  output logic CHAN_IO_B_OUT,
  output logic CHAN_IO_B_OE
);

  // ==========================================================
  // helpers
  // two-bit field of the mode register
  function automatic logic [1:0] fld2(input logic [31:0] v, input int p);
    return v[p +: 2];
  endfunction
  // edge selector: none, rising, falling, each
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    if (sel == EDGE_RISE) begin
      hit = r;
    end else if (sel == EDGE_FALL) begin
      hit = f;
    end else if (sel != EDGE_NONE) begin
      hit = r | f;
    end
    return hit;
  endfunction
  // highest-priority event that carries an action wins
  function automatic logic [1:0] pick(input logic sw, input logic [1:0] a_sw,
                                      input logic ev, input logic [1:0] a_ev,
                                      input logic mc, input logic [1:0] a_c,
                                      input logic mab, input logic [1:0] a_ab);
    logic [1:0] act;
    act = ACT_NONE;
    if (sw && a_sw != ACT_NONE) begin
      act = a_sw;
    end else if (ev && a_ev != ACT_NONE) begin
      act = a_ev;
    end else if (mc && a_c != ACT_NONE) begin
      act = a_c;
    end else if (mab) begin
      act = a_ab;
    end
    return act;
  endfunction
  function automatic logic apply_act(input logic lvl, input logic [1:0] act);
    logic o;
    case (act)
      ACT_NONE: o = lvl;
      ACT_SET: o = 1'b1;
      ACT_CLEAR: o = 1'b0;
      default: o = ~lvl;
    endcase
    return o;
  endfunction

  // ==========================================================
  // state
  tcm_state_t s_r;
  tcm_state_t s_nxt;
  logic [31:0] cm;
  logic wave;
  logic [2:0] xc;
  logic [SY_W-1:0] rise;
  logic [SY_W-1:0] fall;
  logic [2:0] clk_sel;
  logic [1:0] gate_sel;
  logic clk_lvl;
  logic tick;
  logic run_tick;
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic [7:0] wa;
  logic sw_trg;
  logic cap_trg;
  logic ev_line_r;
  logic ev_line_f;
  logic ev_hit;
  logic ev_trg;
  logic match_a;
  logic match_b;
  logic match_c;
  logic load_a;
  logic load_b;
  logic io_b_is_out;

  // ==========================================================
  // event decode
  assign cm = s_r.channel_mode;
  assign wave = cm[F_CAPTURE_OR_PULSE_MODE];
  assign xc = s_r.sync2[2:0];
  assign rise = s_r.sync2 & ~s_r.prev;
  assign fall = ~s_r.sync2 & s_r.prev;
  assign clk_sel = cm[F_CLOCK_SELECT +: 3];
  assign gate_sel = fld2(cm, F_CLOCK_GATE_SELECT);

  // selected clock level, gated by an ext line when asked
  always_comb begin
    if (clk_sel == SEL_DIV2) begin
      clk_lvl = s_r.presc[DIV2_BIT];
    end else if (clk_sel == SEL_DIV8) begin
      clk_lvl = s_r.presc[DIV8_BIT];
    end else if (clk_sel == SEL_DIV32) begin
      clk_lvl = s_r.presc[DIV32_BIT];
    end else if (clk_sel == SEL_DIV128) begin
      clk_lvl = s_r.presc[DIV128_BIT];
    end else if (clk_sel == SEL_DIV1024) begin
      clk_lvl = s_r.presc[DIV1024_BIT];
    end else if (clk_sel == SEL_EXT0) begin
      clk_lvl = xc[0];
    end else if (clk_sel == SEL_EXT1) begin
      clk_lvl = xc[1];
    end else begin
      clk_lvl = xc[2];
    end
    if (gate_sel != 2'h0) begin
      clk_lvl = clk_lvl & xc[gate_sel - 2'h1];
    end
  end

  // count edge of the selected clock, sampled on the master clock
  assign tick = cm[F_CLOCK_EDGE_INVERT] ? (s_r.clk_lvl_prev & ~clk_lvl)
                                        : (~s_r.clk_lvl_prev & clk_lvl);
  assign run_tick = tick & s_r.clk_en & s_r.clk_run;

  // bus phases; writes commit on the access edge only
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_access = PSEL & PENABLE & s_r.pready;
  assign apb_wr = apb_access & PWRITE;
  assign wa = PADDR;
  assign sw_trg = apb_wr && wa == OFS_CHANNEL_CONTROL && PWDATA[C_SOFT_TRIGGER];

  // capture trigger on io a or io b
  assign cap_trg = ~wave & (cm[F_TRIGGER_LINE_SELECT]
    ? edge_hit(fld2(cm, F_EDGE_SELECT), rise[SY_IO_A], fall[SY_IO_A])
    : edge_hit(fld2(cm, F_EDGE_SELECT), rise[SY_IO_B], fall[SY_IO_B]));

  // waveform external event: io b or one of the ext lines
  always_comb begin
    if (fld2(cm, F_EVENT_LINE_SELECT) == 2'h0) begin
      ev_line_r = rise[SY_IO_B];
      ev_line_f = fall[SY_IO_B];
    end else begin
      ev_line_r = rise[fld2(cm, F_EVENT_LINE_SELECT) - 2'h1];
      ev_line_f = fall[fld2(cm, F_EVENT_LINE_SELECT) - 2'h1];
    end
  end
  assign ev_hit = wave & edge_hit(fld2(cm, F_EDGE_SELECT), ev_line_r, ev_line_f);
  assign ev_trg = ev_hit & cm[F_EVENT_TRIGGER_ENABLE];
  assign io_b_is_out = wave && fld2(cm, F_EVENT_LINE_SELECT) != 2'h0;

  // compares fire on a counting edge while the count equals the register
  assign match_c = run_tick && s_r.count == s_r.pc_c;
  assign match_a = wave && run_tick && s_r.count == s_r.cc_a;
  assign match_b = wave && run_tick && s_r.count == s_r.cc_b;
  assign load_a = ~wave & edge_hit(fld2(cm, F_A_LOAD_EDGE_SELECT),
                                   rise[SY_IO_A], fall[SY_IO_A]);
  assign load_b = ~wave & edge_hit(fld2(cm, F_B_LOAD_EDGE_SELECT),
                                   rise[SY_IO_A], fall[SY_IO_A]);

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // pins pass two flops; prev only sees the settled copy
    s_nxt.sync1 = {CHAN_IO_B_IN, CHAN_IO_A_IN, EXT_CLOCK_LINE_2, EXT_CLOCK_LINE_1,
                   EXT_CLOCK_LINE_0};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    s_nxt.presc = PRESCALE_W'(s_r.presc + 1'b1);
    s_nxt.clk_lvl_prev = clk_lvl;
    // status read clears the bits it reported first, so a set below wins
    if (apb_access && !PWRITE && wa == OFS_CHANNEL_STATUS) begin
      s_nxt.sticky = s_r.sticky & ~s_r.prdata[STICKY_W-1:0];
    end

    // counter: any trigger restarts from zero, else count and wrap
    if (sw_trg || cap_trg || ev_trg || (match_c && cm[F_COMPARE_C_TRIGGER_ENABLE])) begin
      s_nxt.count = RST_COUNT;
      s_nxt.clk_run = 1'b1;
    end else if (run_tick) begin
      s_nxt.count = 16'(s_r.count + 1'b1);
      if (s_r.count == COUNT_MAX) begin
        s_nxt.sticky[S_OVERFLOW] = 1'b1;
      end
    end

    // stop and disable have the last word over a trigger
    if (wave && match_c && cm[F_STOP_BIT]) begin
      s_nxt.clk_run = 1'b0;
    end
    if (wave && match_c && cm[F_DISABLE_BIT]) begin
      s_nxt.clk_en = 1'b0;
    end
    if (load_b && cm[F_STOP_BIT]) begin
      s_nxt.clk_run = 1'b0;
    end
    if (load_b && cm[F_DISABLE_BIT]) begin
      s_nxt.clk_en = 1'b0;
    end

    // capture loads; a second load before a read is an overrun
    if (load_a) begin
      s_nxt.cc_a = s_r.count;
      s_nxt.a_unread = 1'b1;
      s_nxt.sticky[S_LOAD_A] = 1'b1;
      if (s_r.a_unread) begin
        s_nxt.sticky[S_LOAD_OVERRUN] = 1'b1;
      end
    end
    if (load_b) begin
      s_nxt.cc_b = s_r.count;
      s_nxt.b_unread = 1'b1;
      s_nxt.sticky[S_LOAD_B] = 1'b1;
      if (s_r.b_unread) begin
        s_nxt.sticky[S_LOAD_OVERRUN] = 1'b1;
      end
    end

    // waveform outputs; capture mode leaves both lines undriven
    s_nxt.io_a_oe = wave;
    s_nxt.io_b_oe = io_b_is_out;
    if (wave) begin
      s_nxt.io_a = apply_act(s_r.io_a,
        pick(sw_trg, fld2(cm, F_OUT_A_ON_SOFT_TRIGGER), ev_hit,
             fld2(cm, F_OUT_A_ON_EVENT), match_c, fld2(cm, F_OUT_A_ON_COMPARE_C),
             match_a, fld2(cm, F_OUT_A_ON_COMPARE_A)));
    end
    if (io_b_is_out) begin
      s_nxt.io_b = apply_act(s_r.io_b,
        pick(sw_trg, fld2(cm, F_OUT_B_ON_SOFT_TRIGGER), ev_hit,
             fld2(cm, F_OUT_B_ON_EVENT), match_c, fld2(cm, F_OUT_B_ON_COMPARE_C),
             match_b, fld2(cm, F_OUT_B_ON_COMPARE_B)));
    end

    // a read of register a or b clears its unread mark; a new load wins
    if (apb_access && !PWRITE && wa == OFS_CAPTURE_COMPARE_A && !load_a) begin
      s_nxt.a_unread = 1'b0;
    end
    if (apb_access && !PWRITE && wa == OFS_CAPTURE_COMPARE_B && !load_b) begin
      s_nxt.b_unread = 1'b0;
    end
    if (match_a) begin
      s_nxt.sticky[S_COMPARE_A] = 1'b1;
    end
    if (match_b) begin
      s_nxt.sticky[S_COMPARE_B] = 1'b1;
    end
    if (match_c) begin
      s_nxt.sticky[S_COMPARE_C] = 1'b1;
    end
    if (cap_trg || ev_hit) begin
      s_nxt.sticky[S_EXT_TRIGGER] = 1'b1;
    end

    // register writes
    if (apb_wr) begin
      if (wa == OFS_CHANNEL_CONTROL) begin
        if (PWDATA[C_CLOCK_DISABLE]) begin
          s_nxt.clk_en = 1'b0;
        end else if (PWDATA[C_CLOCK_ENABLE]) begin
          s_nxt.clk_en = 1'b1;
        end
      end else if (wa == OFS_CHANNEL_MODE) begin
        s_nxt.channel_mode = PWDATA;
      end else if (wa == OFS_CAPTURE_COMPARE_A && wave) begin
        s_nxt.cc_a = PWDATA[15:0];
      end else if (wa == OFS_CAPTURE_COMPARE_B && wave) begin
        s_nxt.cc_b = PWDATA[15:0];
      end else if (wa == OFS_PERIOD_COMPARE_C) begin
        s_nxt.pc_c = PWDATA[15:0];
      end
    end

    // setup phase prepares the answer; access phase releases it
    s_nxt.pready = apb_setup;
    if (apb_setup) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      if (PADDR == OFS_CHANNEL_MODE) begin
        s_nxt.prdata = cm;
      end else if (PADDR == OFS_COUNTER_VALUE) begin
        s_nxt.prdata[15:0] = s_r.count;
      end else if (PADDR == OFS_CAPTURE_COMPARE_A) begin
        s_nxt.prdata[15:0] = s_r.cc_a;
      end else if (PADDR == OFS_CAPTURE_COMPARE_B) begin
        s_nxt.prdata[15:0] = s_r.cc_b;
      end else if (PADDR == OFS_PERIOD_COMPARE_C) begin
        s_nxt.prdata[15:0] = s_r.pc_c;
      end else if (PADDR == OFS_CHANNEL_STATUS) begin
        s_nxt.prdata[STICKY_W-1:0] = s_r.sticky;
        s_nxt.prdata[S_CLOCK_ENABLED] = s_r.clk_en;
        s_nxt.prdata[S_MIRROR_A] = wave ? s_r.io_a : s_r.sync2[SY_IO_A];
        s_nxt.prdata[S_MIRROR_B] = io_b_is_out ? s_r.io_b : s_r.sync2[SY_IO_B];
      end else if (PADDR != OFS_CHANNEL_CONTROL) begin
        s_nxt.pslverr = 1'b1; // unmapped: error; control is write-only and reads zero
      end
    end else if (apb_access) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
    end
  end

  // ==========================================================
  // the only clocked process
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign CHAN_IO_A_OUT = s_r.io_a;
  assign CHAN_IO_A_OE = s_r.io_a_oe;
  assign CHAN_IO_B_OUT = s_r.io_b;
  assign CHAN_IO_B_OE = s_r.io_b_oe;

endmodule

/* tcm_far_end.sv */
/*
  far end of the channel pins: three ext clock lines and io lines a and b.
  assumes the bench calls its tasks just after a rising clock edge.
*/
module tcm_far_end (
  output logic [2:0] ext_lines,
  output logic io_a_wire,
  output logic io_b_wire,
  input wire logic io_a_out,
  input wire logic io_a_oe,
  input wire logic io_b_out,
  input wire logic io_b_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic io_a_drv = 1'b0;
  initial ext_lines = 3'h0;
  // the channel wins a pin while its enable is high; io b is pulled low otherwise
  assign io_a_wire = io_a_oe ? io_a_out : io_a_drv;
  assign io_b_wire = io_b_oe ? io_b_out : 1'b0;
  task automatic set_ext(input int n, input logic v);
    ext_lines[n] <= v;
  endtask
  task automatic set_io_a(input logic v);
    io_a_drv <= v;
  endtask
endmodule

/* tcm_channel_sva.sv */
/*
  assertions on the channel's bus port and io enables.
  assumes it is bound to tcm_channel and sees only its ports.
*/
module tcm_channel_sva
  import tcm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CHAN_IO_A_OUT,
  input wire logic CHAN_IO_A_OE,
  input wire logic CHAN_IO_B_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // helpers: mode write strobe, last mode word, mapped offsets
  logic mode_wr;
  logic mapped;
  logic [31:0] mode_r;
  assign mode_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_CHANNEL_MODE;
  assign mapped = PADDR inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      mode_r <= RST_CHANNEL_MODE;
    end else if (mode_wr) begin
      mode_r <= PWDATA;
    end
  end
  // ==========================================================
  // bus handshake
  ready_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  error_decode_a: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error response disagrees with map");
  idle_data_zero_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  // ==========================================================
  // register contents and pin directions
  count_upper_zero_a: assert property (
    PREADY && !PWRITE && PADDR == OFS_COUNTER_VALUE |-> PRDATA[31:16] == 16'h0)
    else $error("counter upper half set");
  mode_readback_a: assert property (
    PREADY && !PWRITE && PADDR == OFS_CHANNEL_MODE |-> PRDATA == mode_r)
    else $error("mode reads back wrong");
  a_drive_mode_a: assert property (
    !mode_wr [*3] |-> CHAN_IO_A_OE == mode_r[F_CAPTURE_OR_PULSE_MODE])
    else $error("io a direction wrong");
  b_drive_mode_a: assert property (
    !mode_wr [*3] |-> CHAN_IO_B_OE == (mode_r[15] && mode_r[11:10] != 2'h0))
    else $error("io b direction wrong");
  // main scenarios reached
  cover property (mode_wr);
  cover property (PSLVERR);
  cover property ($rose(CHAN_IO_A_OUT));
endmodule

/* timer_channel_mode_control_test.sv */
/*
  self-checking bench for the timer channel: bus tasks, pin stimulus through
  the far-end model, checks of counting, capture and waveforms.
  assumes the package, channel, checker and far-end model compile first.
*/
module timer_channel_mode_control_test import tcm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, q, c0;
  logic PREADY, PSLVERR, e, expv, io_a, io_b, a_out, a_oe, b_out, b_oe;
  logic [2:0] ext;
  logic [1:0] seen = 2'h0;
  int errors = 0;
  int n_compared = 0;
  int div[5] = '{2, 8, 32, 128, 1024};
  logic [1:0] acts[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  tcm_channel i_dut (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EXT_CLOCK_LINE_0(ext[0]), .EXT_CLOCK_LINE_1(ext[1]),
    .EXT_CLOCK_LINE_2(ext[2]), .CHAN_IO_A_IN(io_a), .CHAN_IO_A_OUT(a_out),
    .CHAN_IO_A_OE(a_oe), .CHAN_IO_B_IN(io_b), .CHAN_IO_B_OUT(b_out), .CHAN_IO_B_OE(b_oe));
  tcm_far_end i_far (.ext_lines(ext), .io_a_wire(io_a), .io_b_wire(io_b),
    .io_a_out(a_out), .io_a_oe(a_oe), .io_b_out(b_out), .io_b_oe(b_oe));
  // ==========================================================
  // one bus transfer; read data and error land in q and e
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n == 16) chk(32'h0, 32'h1);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  // two counter reads sampled n+3 cycles apart; first lands in c0
  task automatic two_reads(input int n);
    apb(0, OFS_COUNTER_VALUE, 0);
    c0 = q;
    cyc(n);
    apb(0, OFS_COUNTER_VALUE, 0);
  endtask
  // ==========================================================
  // clock, and a watchdog well past the expected run length
  always #10 MCLK = ~MCLK;
  initial begin
    #1_000_000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge MCLK);
    RESET <= 1'b0;
    // reset values, an unmapped offset, register a write access by mode
    apb(0, OFS_CHANNEL_MODE, 0);
    chk(q, RST_CHANNEL_MODE);
    apb(0, OFS_COUNTER_VALUE, 0);
    chk(q, 32'h0);
    apb(1, 8'h08, 32'h5);
    chk({31'h0, e}, 32'h1);
    apb(1, OFS_CAPTURE_COMPARE_A, 32'h1234);
    apb(0, OFS_CAPTURE_COMPARE_A, 0);
    chk(q, 32'h0);
    apb(1, OFS_CHANNEL_MODE, 32'h8000);
    apb(1, OFS_CAPTURE_COMPARE_A, 32'h1234);
    apb(0, OFS_CAPTURE_COMPARE_A, 0);
    chk(q, 32'h1234);
    // counter ignores writes and idles until a trigger starts it
    apb(1, OFS_COUNTER_VALUE, 32'h55);
    apb(1, OFS_CHANNEL_MODE, 32'h0);
    apb(1, OFS_CHANNEL_CONTROL, 32'h1);
    two_reads(3);
    chk(q, 32'h0);
    // every divided rate counts twice in a window of two periods
    for (int i = 0; i < 5; i++) begin
      apb(1, OFS_CHANNEL_MODE, 32'(i));
      apb(1, OFS_CHANNEL_CONTROL, 32'h5);
      two_reads(2 * div[i] - 3);
      chk(q - c0, 32'h2);
    end
    // ext line 0 as clock: which edge counts depends on invert
    for (int k = 0; k < 2; k++) begin
      apb(1, OFS_CHANNEL_MODE, 32'h5 | 32'(k << 3));
      apb(1, OFS_CHANNEL_CONTROL, 32'h5);
      i_far.set_ext(0, 1'b1);
      cyc(8);
      apb(0, OFS_COUNTER_VALUE, 0);
      chk(q, 32'(1 - k));
      i_far.set_ext(0, 1'b0);
      cyc(8);
      apb(0, OFS_COUNTER_VALUE, 0);
      chk(q, 32'h1);
    end
    // ext line 0 low gates the /2 clock: the counter holds at zero
    apb(1, OFS_CHANNEL_MODE, 32'h10);
    apb(1, OFS_CHANNEL_CONTROL, 32'h5);
    two_reads(3);
    chk(q, 32'h0);
    // soft trigger on both io lines: set, clear, toggle, toggle
    expv = 1'b0;
    foreach (acts[k]) begin
      apb(1, OFS_CHANNEL_MODE, 32'h8405 | {acts[k], 6'h0, acts[k], 22'h0});
      apb(1, OFS_CHANNEL_CONTROL, 32'h5);
      expv = (acts[k] == 2'h3) ? !expv : (acts[k] == 2'h1);
      cyc(3);
      chk({30'h0, a_out, b_out}, {30'h0, expv, expv});
    end
    // period of four counts: a set on match a, cleared on match c
    apb(1, OFS_PERIOD_COMPARE_C, 32'h3);
    apb(1, OFS_CAPTURE_COMPARE_A, 32'h1);
    apb(1, OFS_CHANNEL_MODE, 32'h0009_c400);
    apb(1, OFS_CHANNEL_CONTROL, 32'h5);
    c0 = 32'h0;
    for (int k = 0; k < 12; k++) begin
      apb(0, OFS_COUNTER_VALUE, 0);
      if (q > c0) c0 = q;
      seen = seen | {a_out, !a_out};
    end
    chk(c0, 32'h3);
    chk({30'h0, seen}, 32'h3);
    // match c with stop keeps the clock enabled, with disable turns it off
    for (int k = 0; k < 2; k++) begin
      apb(1, OFS_CHANNEL_MODE, 32'h8400 | 32'(8'h40 << k));
      apb(1, OFS_CHANNEL_CONTROL, 32'h5);
      cyc(20);
      two_reads(4);
      chk(q, c0);
      apb(0, OFS_CHANNEL_STATUS, 0);
      chk({31'h0, q[S_CLOCK_ENABLED]}, 32'(1 - k));
    end
    // capture a on rise and b on fall of io a; b load stops or disables
    for (int k = 0; k < 2; k++) begin
      apb(1, OFS_CHANNEL_MODE, 32'h0009_0000 | 32'(8'h40 << k));
      cyc(8); // a released io a may fall here; let that load pass before the trigger
      apb(1, OFS_CHANNEL_CONTROL, 32'h5);
      i_far.set_io_a(1'b1);
      cyc(10);
      i_far.set_io_a(1'b0);
      cyc(10);
      apb(0, OFS_CAPTURE_COMPARE_B, 0);
      c0 = q;
      apb(0, OFS_CAPTURE_COMPARE_A, 0);
      chk(c0 - q, 32'h5);
      two_reads(4);
      chk(q, c0);
      apb(0, OFS_CHANNEL_STATUS, 0);
      chk({31'h0, q[S_CLOCK_ENABLED]}, 32'(1 - k));
    end
    // rising edge on ext line 1 toggles a and restarts the running counter
    apb(1, OFS_CHANNEL_MODE, 32'h0030_9900);
    apb(1, OFS_CHANNEL_CONTROL, 32'h1);
    expv = a_out;
    i_far.set_ext(1, 1'b1);
    cyc(10);
    chk({31'h0, a_out}, {31'h0, !expv});
    two_reads(4);
    chk({31'h0, q != c0}, 32'h1);
    chk(c0, 32'h4);
    // rising io a as capture trigger restarts the running counter
    apb(1, OFS_CHANNEL_MODE, 32'h0000_0500);
    cyc(4);
    i_far.set_io_a(1'b1);
    cyc(6);
    apb(0, OFS_COUNTER_VALUE, 0);
    chk(q, 32'h2);
    tally_and_finish();
  end
endmodule

bind tcm_channel tcm_channel_sva i_sva (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CHAN_IO_A_OUT(CHAN_IO_A_OUT),
  .CHAN_IO_A_OE(CHAN_IO_A_OE), .CHAN_IO_B_OE(CHAN_IO_B_OE));
